// [logic/key_detect.sv]
`timescale 1ns/1ps
`include "key_input_interrupt_map.svh"

module key_detect
  import key_input_interrupt_pkg::*;
(
  input  wire logic     hclk,
  input  wire logic     hresetn,
  input  wire logic     clear,
  input  wire key_vec_t sample,
  input  wire key_vec_t enable,
  input  wire key_vec_t polarity,
  output key_vec_t      edge_hit,
  output key_vec_t      level_hit
);

  key_vec_t prev;

  // ----------------------------------------------------------------------------
  // Per-input edge and level test on two consecutive bus-cycle samples
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < `KEY_WIDTH; i++) begin : g_bit
    // Previous sample tracks even disabled pins, so enabling never fakes an edge
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        prev[i] <= 1'b0;
      end else if (clear) begin
        prev[i] <= 1'b0;
      end else begin
        prev[i] <= sample[i];
      end
    end

    // Prior sample must be deasserted, so a held level gives no edge
    assign edge_hit[i]  = enable[i] & (polarity[i] ? (~prev[i] & sample[i])
                                                   : (prev[i] & ~sample[i]));
    assign level_hit[i] = enable[i] & (sample[i] == polarity[i]);
  end

endmodule // key_detect

// [logic/key_input_interrupt.sv]
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "key_input_interrupt_map.svh"

// Function
// - Keep working normally during background debug halt
// - Status register bits 7:4 read zero
// - Bit 3 shows event flag, writes ignored
// - Bit 2 write-one acknowledge, reads zero
// - Bit 1 gates the interrupt request
// - Bit 0 selects edge or edge-and-level
// - Pin enable bit makes input a source
// - Polarity bit picks falling/low or rising/high
// - Falling edge: high then low sample
// - Rising edge: low then high sample
// - Edge mode: valid edge sets flag
// - Request while flag set and enabled
// - Edge mode: acknowledge clears flag
// - Level mode: edge or level sets flag
// - Level mode: acknowledge needs all inputs deasserted
// - Polarity picks pull-up or pull-down resistor
// - Enabling an input may raise flag
// - Light stop: asynchronous detection wakes device
// - Deep stop disables, returns in reset

module key_input_interrupt
  import key_input_interrupt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire key_vec_t    key_input_pin,
  input  wire logic        light_stop,
  input  wire logic        deep_stop,
  output logic             key_irq,
  output logic             key_wake,
  output key_vec_t         pull_down_select
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  reg_sel_t  addr_sel;
  reg_sel_t  next_sel;
  logic      wr_pending;
  logic      wr_lane0;
  logic      next_lane0;
  logic      accept;
  logic      wr_sc;
  logic      wr_pe;
  logic      wr_es;
  logic      wr_commit;
  logic      rd_accept;
  logic      hit_sc;
  logic      hit_pe;
  logic      hit_es;
  logic [7:0] wdata;

  logic      detect_mode_select;
  logic      key_irq_enable;
  logic      key_event_flag;
  key_vec_t  key_pin_enable;
  key_vec_t  key_polarity_select;

  key_vec_t  pin_sampled;
  key_vec_t  edge_hit;
  key_vec_t  level_hit;
  logic      any_edge;
  logic      any_level;
  logic      flag_set;
  logic      flag_clear;
  logic      key_event_acknowledge;
  logic      ack_blocked;
  logic      next_flag;

  key_vec_t  async_asserted;
  logic [7:0] status_read;
  logic [31:0] next_rdata;
  logic [31:0] sc_word;
  logic [31:0] pe_word;
  logic [31:0] es_word;
  logic      wake_source;
  logic      wake_allowed;

  // ----------------------------------------------------------------------------
  // AHB-Lite address phase
  // ----------------------------------------------------------------------------
  // Zero wait state slave; every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp     = `AHB_RESP_OKAY;

  assign accept    = hsel & hready & htrans[1];
  assign rd_accept = accept & ~hwrite;

  // ----------------------------------------------------------------------------
  // Register hit decode
  // ----------------------------------------------------------------------------
  // Only the low byte is compared; hsel already picks the block
  assign hit_sc = (haddr[`KEY_DECODE_MSB:0] == `KEY_STATUS_CONTROL_OFS);
  assign hit_pe = (haddr[`KEY_DECODE_MSB:0] == `KEY_PIN_ENABLE_OFS);
  assign hit_es = (haddr[`KEY_DECODE_MSB:0] == `KEY_POLARITY_OFS);

  // Unmapped offsets select nothing, so they read zero and ignore writes
  always_comb begin
    next_sel = SEL_NONE;
    if (hit_sc) begin
      next_sel = SEL_SC;
    end else if (hit_pe) begin
      next_sel = SEL_PE;
    end else if (hit_es) begin
      next_sel = SEL_ES;
    end else begin
      next_sel = SEL_NONE;
    end
  end

  // Registers live in byte lane 0; narrower writes elsewhere are dropped
  always_comb begin
    next_lane0 = 1'b1;
    if (hsize == `AHB_SIZE_BYTE) begin
      next_lane0 = (haddr[1:0] == 2'b00);
    end else if (hsize == `AHB_SIZE_HALF) begin
      next_lane0 = ~haddr[1];
    end else begin
      next_lane0 = 1'b1;
    end
  end

  // Register select is captured only on an accepted transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_sel <= SEL_NONE;
    end else if (hready) begin
      addr_sel <= accept ? next_sel : SEL_NONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
    end else if (hready) begin
      wr_pending <= accept & hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_lane0 <= 1'b0;
    end else if (hready) begin
      wr_lane0 <= next_lane0;
    end
  end

  // ----------------------------------------------------------------------------
  // Write strobes in the data phase
  // ----------------------------------------------------------------------------
  // A write lands only when its transfer covered byte lane 0
  assign wr_commit = wr_pending & wr_lane0;
  assign wdata     = hwdata[7:0];
  assign wr_sc     = wr_commit & (addr_sel == SEL_SC);
  assign wr_pe     = wr_commit & (addr_sel == SEL_PE);
  assign wr_es     = wr_commit & (addr_sel == SEL_ES);

  // Acknowledge is a pulse only; it is never stored
  assign key_event_acknowledge = wr_sc & wdata[`KEY_ACK_BIT];

  // ----------------------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------------------
  // Deep stop holds everything at reset so the block wakes up cleared
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      detect_mode_select <= `KEY_CTRL_RESET;
    end else if (deep_stop) begin
      detect_mode_select <= `KEY_CTRL_RESET;
    end else if (wr_sc) begin
      detect_mode_select <= wdata[`KEY_MODE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_irq_enable <= `KEY_CTRL_RESET;
    end else if (deep_stop) begin
      key_irq_enable <= `KEY_CTRL_RESET;
    end else if (wr_sc) begin
      key_irq_enable <= wdata[`KEY_IRQ_EN_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // Pin enable and polarity
  // ----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_pin_enable <= `KEY_VEC_RESET;
    end else if (deep_stop) begin
      key_pin_enable <= `KEY_VEC_RESET;
    end else if (wr_pe) begin
      key_pin_enable <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_polarity_select <= `KEY_VEC_RESET;
    end else if (deep_stop) begin
      key_polarity_select <= `KEY_VEC_RESET;
    end else if (wr_es) begin
      key_polarity_select <= wdata;
    end
  end

  // Port resistor direction follows polarity: 0 pull-up, 1 pull-down
  assign pull_down_select = key_polarity_select;

  // ----------------------------------------------------------------------------
  // Input sampling and detection
  // ----------------------------------------------------------------------------
  key_sync u_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_async (key_input_pin),
    .pin_sync  (pin_sampled)
  );

  // There is no debug-halt input at all, so detection cannot be frozen
  key_detect u_detect (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clear     (deep_stop),
    .sample    (pin_sampled),
    .enable    (key_pin_enable),
    .polarity  (key_polarity_select),
    .edge_hit  (edge_hit),
    .level_hit (level_hit)
  );

  assign any_edge  = |edge_hit;
  // In level mode an input enabled while already asserted sets the flag at once
  assign any_level = |level_hit;

  // ----------------------------------------------------------------------------
  // Event flag
  // ----------------------------------------------------------------------------
  // In level mode an enabled input still asserted holds the flag through an ack
  assign ack_blocked = any_level;

  always_comb begin
    flag_set   = 1'b0;
    flag_clear = 1'b0;
    if (detect_mode_select) begin
      flag_set   = any_edge | any_level;
      flag_clear = key_event_acknowledge & ~ack_blocked;
    end else begin
      flag_set   = any_edge;
      flag_clear = key_event_acknowledge;
    end
  end

  // A detection in the acknowledge cycle wins over the clear
  assign next_flag = flag_set | (key_event_flag & ~flag_clear);

  // Bus writes reach the flag only through the acknowledge path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_event_flag <= `KEY_FLAG_RESET;
    end else if (deep_stop) begin
      key_event_flag <= `KEY_FLAG_RESET;
    end else begin
      key_event_flag <= next_flag;
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt request and wake
  // ----------------------------------------------------------------------------
  assign key_irq = key_event_flag & key_irq_enable;

  // ----------------------------------------------------------------------------
  // Light stop wake
  // ----------------------------------------------------------------------------
  // Unclocked path so an asserted pin wakes the part with the clock stopped.
  // A short pulse may wake but leave no flag if it ends before sampling resumes.
  always_comb begin
    for (int i = 0; i < `KEY_WIDTH; i++) begin
      async_asserted[i] = key_pin_enable[i] & (key_input_pin[i] == key_polarity_select[i]);
    end
  end

  assign wake_source  = (|async_asserted) | key_event_flag;
  // Deep stop wins even if light stop is still flagged
  assign wake_allowed = light_stop & ~deep_stop & key_irq_enable;
  assign key_wake     = wake_allowed & wake_source;

  // ----------------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------------
  always_comb begin
    status_read                     = 8'h00;
    status_read[`KEY_FLAG_BIT]      = key_event_flag;
    status_read[`KEY_ACK_BIT]       = 1'b0;
    status_read[`KEY_IRQ_EN_BIT]    = key_irq_enable;
    status_read[`KEY_MODE_BIT]      = detect_mode_select;
  end

  // Eight bits in lane 0 of each word; the upper bits read zero
  assign sc_word = {24'h00_0000, status_read};
  assign pe_word = {24'h00_0000, key_pin_enable};
  assign es_word = {24'h00_0000, key_polarity_select};

  always_comb begin
    next_rdata = `KEY_RDATA_RESET;
    if (next_sel == SEL_SC) begin
      next_rdata = sc_word;
    end else if (next_sel == SEL_PE) begin
      next_rdata = pe_word;
    end else if (next_sel == SEL_ES) begin
      next_rdata = es_word;
    end else begin
      next_rdata = `KEY_RDATA_RESET;
    end
  end

  // Captured at the address phase, so it shows the state of that edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `KEY_RDATA_RESET;
    end else if (rd_accept) begin
      hrdata <= next_rdata;
    end
  end

endmodule // key_input_interrupt

// [logic/key_sync.sv]
`timescale 1ns/1ps
`include "key_input_interrupt_map.svh"

module key_sync
  import key_input_interrupt_pkg::*;
(
  input  wire logic     hclk,
  input  wire logic     hresetn,
  input  wire key_vec_t pin_async,
  output key_vec_t      pin_sync
);

  key_vec_t stage1;

  // ----------------------------------------------------------------------------
  // Two flops per pin; stage1 feeds stage two only
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < `KEY_WIDTH; i++) begin : g_bit
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stage1[i]   <= 1'b0;
        pin_sync[i] <= 1'b0;
      end else begin
        stage1[i]   <= pin_async[i];
        pin_sync[i] <= stage1[i];
      end
    end
  end

endmodule // key_sync

// [shared/key_input_interrupt_map.svh]
`ifndef KEY_INPUT_INTERRUPT_MAP_SVH
`define KEY_INPUT_INTERRUPT_MAP_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define KEY_WIDTH             8
`define KEY_DECODE_MSB        7

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define KEY_STATUS_CONTROL_OFS 8'h00
`define KEY_PIN_ENABLE_OFS     8'h04
`define KEY_POLARITY_OFS       8'h08

// ----------------------------------------------------------------------------
// Status and control field positions
// ----------------------------------------------------------------------------
`define KEY_MODE_BIT          0
`define KEY_IRQ_EN_BIT        1
`define KEY_ACK_BIT           2
`define KEY_FLAG_BIT          3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define KEY_CTRL_RESET        1'b0
`define KEY_FLAG_RESET        1'b0
`define KEY_VEC_RESET         8'h00
`define KEY_RDATA_RESET       32'h0000_0000

// ----------------------------------------------------------------------------
// AHB encodings
// ----------------------------------------------------------------------------
`define AHB_SIZE_BYTE         3'h0
`define AHB_SIZE_HALF         3'h1
`define AHB_RESP_OKAY         1'b0

`endif

// [shared/key_input_interrupt_pkg.sv]
package key_input_interrupt_pkg;

  typedef logic [7:0] key_vec_t;

  // One-hot register select captured in the address phase
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0001,
    SEL_SC   = 4'b0010,
    SEL_PE   = 4'b0100,
    SEL_ES   = 4'b1000
  } reg_sel_t;

endpackage

// [tb/key_input_interrupt_sva.sv]
`timescale 1ns/1ps

module key_input_interrupt_sva
  import key_input_interrupt_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire key_vec_t    key_input_pin,
  input wire logic        light_stop,
  input wire logic        deep_stop,
  input wire logic        key_irq,
  input wire logic        key_wake,
  input wire key_vec_t    pull_down_select
);
  logic     wr_p, rd_sc, rd_bad, ie, md;
  logic [7:0] wa;
  key_vec_t pe, es;
  wire      acc = hsel & hready & htrans[1];
  wire      ok_edge = ie & ~md & pe[0] & ~es[0] & ~deep_stop;
  wire      lvl = ie & md & pe[0] & (key_input_pin[0] == es[0]) & ~deep_stop;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------
  // Bus phase tracking
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_p <= 1'b0;
      rd_sc <= 1'b0;
      rd_bad <= 1'b0;
      wa <= 8'h00;
    end else begin
      wr_p <= acc & hwrite;
      rd_sc <= acc & !hwrite & (haddr[7:0] == 8'h00);
      rd_bad <= acc & !hwrite & (haddr[7:0] > 8'h08);
      wa <= haddr[7:0];
    end
  end

  // Shadow of the control bits, cleared like the block in deep stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ie, md, pe, es} <= 18'h0_0000;
    end else if (deep_stop) begin
      {ie, md, pe, es} <= 18'h0_0000;
    end else if (wr_p) begin
      case (wa)
        8'h00: {ie, md} <= hwdata[1:0];
        8'h04: pe <= hwdata[7:0];
        8'h08: es <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_high_then_low;
    (key_input_pin[0] && ok_edge) [*4] ##1 (!key_input_pin[0] && ok_edge);
  endsequence

  sequence s_level_held;
    lvl [*4];
  endsequence

  a_bus_okay:      assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  a_edge_sets:     assert property (s_high_then_low |-> ##3 key_irq) else $error("edge missed");
  a_level_holds:   assert property (s_level_held |-> key_irq) else $error("level lost");
  a_irq_masked:    assert property (!ie |-> !key_irq) else $error("request while masked");
  a_pull_select:   assert property (pull_down_select == es) else $error("resistor select wrong");
  a_sc_read_bits:  assert property (rd_sc |-> hrdata[7:4] == 4'h0 && !hrdata[2]) else $error("zero bits set");
  a_unmapped_zero: assert property (rd_bad |-> hrdata == 32'h0000_0000) else $error("unmapped not zero");
  a_wake_gate:     assert property (key_wake |-> light_stop && !deep_stop && ie) else $error("wake ungated");
  a_deep_clears:   assert property (deep_stop |=> !key_irq && pull_down_select == 8'h00) else $error("deep kept");
  a_reset_clear:   assert property ($rose(hresetn) |-> !key_irq && hrdata == 32'h0000_0000) else $error("reset");
endmodule // key_input_interrupt_sva

bind key_input_interrupt key_input_interrupt_sva u_key_input_interrupt_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .key_input_pin(key_input_pin), .light_stop(light_stop), .deep_stop(deep_stop), .key_irq(key_irq),
  .key_wake(key_wake), .pull_down_select(pull_down_select)
);

// [tb/key_source_model.sv]
`timescale 1ns/1ps

module key_source_model
  import key_input_interrupt_pkg::*;
(
  input  wire logic       hclk,
  input  wire key_vec_t   target,
  input  wire logic [3:0] lag,
  output key_vec_t        key_input_pin
);
  logic [3:0] cnt = 4'h0;

  initial key_input_pin = 8'h00;

  // A switch settles lag cycles late and then holds its level whole cycles
  always @(posedge hclk) begin
    if (target !== key_input_pin && cnt < lag) begin
      cnt <= cnt + 4'h1;
    end else begin
      key_input_pin <= target;
      cnt <= 4'h0;
    end
  end
endmodule // key_source_model

// [tb/test_key_input_interrupt.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_key_input_interrupt
  import key_input_interrupt_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, light_stop = 1'b0, deep_stop = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  lag = 4'h0;
  logic        hreadyout, hresp, key_irq, key_wake;
  key_vec_t    target = 8'h00, key_input_pin, pull_down_select;
  int          n_mismatch = 0, compares = 0, seed = 85463;
  wire         hready = hreadyout;

  always #12.5 hclk = ~hclk;

  key_input_interrupt u_key_input_interrupt (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .key_input_pin(key_input_pin), .light_stop(light_stop),
    .deep_stop(deep_stop), .key_irq(key_irq), .key_wake(key_wake), .pull_down_select(pull_down_select));

  key_source_model u_key_source_model (.hclk(hclk), .target(target), .lag(lag), .key_input_pin(key_input_pin));

  task complete_run;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Single word transfer; waits for the slave, bounded against a hang
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) n_mismatch++;
  endtask

  function automatic logic [31:0] sc_val(input logic md, input logic ie, input logic fl);
    return {28'h000_0000, fl, 1'b0, ie, md};
  endfunction

  task chk_sc(input logic [31:0] e);
    bus(1'b0, 8'h00, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  // Mask, polarity, deassert pins, enable, acknowledge, unmask
  task arm(input logic md, input key_vec_t pol, input key_vec_t pe);
    bus(1'b1, 8'h00, {31'h0000_0000, md});
    bus(1'b1, 8'h08, {24'h00_0000, pol});
    target <= ~pol;
    repeat (8) @(posedge hclk);
    bus(1'b1, 8'h04, {24'h00_0000, pe});
    bus(1'b1, 8'h00, {29'h0000_0000, 2'b10, md});
    bus(1'b1, 8'h00, {30'h0000_0000, 1'b1, md});
  endtask

  initial begin
    key_vec_t    pol;
    logic [31:0] v;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, a[7:0], 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    repeat (6) begin
      v = $random(seed);
      bus(1'b1, 8'h04, v);
      bus(1'b0, 8'h04, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, v[7:0]})
      bus(1'b1, 8'h08, {v[7:0], v[31:8]});
      bus(1'b0, 8'h08, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, v[15:8]})
      `CHK(pull_down_select, v[15:8])
    end
    bus(1'b1, 8'h04, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'hFFFF_FFFF);
    chk_sc(sc_val(1'b1, 1'b1, 1'b0));
    for (int p = 0; p < 2; p++) begin
      pol = {8{p[0]}};
      arm(1'b0, pol, 8'h01);
      target <= ~pol ^ 8'h02;
      repeat (6) @(posedge hclk);
      `CHK(key_irq, 1'b0)
      target <= ~pol ^ 8'h03;
      repeat (6) @(posedge hclk);
      `CHK(key_irq, 1'b1)
      bus(1'b1, 8'h00, 32'h0000_000A);
      chk_sc(sc_val(1'b0, 1'b1, 1'b1));
      bus(1'b1, 8'h00, 32'h0000_0006);
      chk_sc(sc_val(1'b0, 1'b1, 1'b0));
    end
    arm(1'b1, 8'h00, 8'h01);
    target <= 8'hFE;
    repeat (6) @(posedge hclk);
    bus(1'b1, 8'h00, 32'h0000_0007);
    chk_sc(sc_val(1'b1, 1'b1, 1'b1));
    light_stop <= 1'b1;
    @(posedge hclk);
    `CHK(key_wake, 1'b1)
    light_stop <= 1'b0;
    lag <= 4'h5;
    target <= 8'hFF;
    repeat (12) @(posedge hclk);
    bus(1'b1, 8'h00, 32'h0000_0007);
    chk_sc(sc_val(1'b1, 1'b1, 1'b0));
    lag <= 4'h0;
    repeat (20) begin
      v = $random(seed);
      target <= {v[7:1], 1'b1};
      repeat (2) @(posedge hclk);
    end
    `CHK(key_irq, 1'b0)
    deep_stop <= 1'b1;
    repeat (2) @(posedge hclk);
    deep_stop <= 1'b0;
    for (int a = 0; a < 12; a += 4) begin
      bus(1'b0, a[7:0], 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    complete_run;
  end

  initial begin
    #100_000;
    n_mismatch++;
    complete_run;
  end
endmodule // test_key_input_interrupt
